// ===== design/rcl_pkg.sv
// Package of constants and types for the reset configuration latch.
package rcl_pkg;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int PART_MIN_NS = 40;
  localparam int PART_MAX_NS = 500;
  localparam int PART_READY_NS = 50;
  localparam int FULL_MIN_PS = 1200000;
  localparam int FULL_READY_MS = 15;
  localparam int PART_MIN_CYC = (PART_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PART_MAX_CYC = (PART_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int PART_READY_CYC = (PART_READY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FULL_MIN_CYC = (FULL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint FULL_READY_CYC_L =
    (64'(FULL_READY_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS);
  localparam int PW_CNT_W = 8;
  localparam int RDY_CNT_W = 20;
  localparam logic [PW_CNT_W-1:0] PW_SAT = 8'hFF;
  localparam logic [1:0] RANGE_SW_CODE = 2'h0;
  localparam logic IFACE_PARALLEL = 1'h0;
  localparam logic IFACE_SERIAL = 1'h1;
  localparam int OVS_W = 3;
  localparam int CHAN_W = 3;

  typedef enum logic [1:0] {RCL_NONE, RCL_PART, RCL_FULL, RCL_UNDEF} rcl_kind_e;

  typedef struct packed {
    logic             hwMode;
    logic             intRefEn;
    logic             serialIf;
    logic             twoLane;
    logic             burst_en_pin;
    logic             seq_en_pin;
    logic [OVS_W-1:0] ovsRatio;
  } rcl_cfg_s;

  localparam rcl_cfg_s CFG_RESET = '0;

endpackage

// ===== design/rcl_pulse_timer.sv
// Counter that measures the low time of the synchronised reset pin.
`timescale 1ns/1ps
module rcl_pulse_timer
  import rcl_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Synchronised pin level.
  input  wire logic                pinLow,
  // Measured width.
  output logic      [PW_CNT_W-1:0] width
);

  logic [PW_CNT_W-1:0] next_width;

  // The count restarts on each low interval and saturates.
  always_comb begin
    next_width = width;
    if (!pinLow) begin
      next_width = '0;
    end else if (width != PW_SAT) begin
      next_width = width + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width <= '0;
    end else begin
      width <= next_width;
    end
  end

endmodule

// ===== design/rcl_reset_config_latch.sv
// Reset classification and strap latch for a dual sampling converter.
// Summary of operation
// R1: At full-reset release, range pins 00 give software mode, else hardware.
// R2: After software mode latches, range pin changes are ignored.
// R3: Latched mode persists until the next full reset.
// R4: Hardware mode refuses all on-chip register access.
// R5: Software mode takes reference, interface and lane select from pins, the rest from registers.
// R6: Reference select pin latched at full-reset release; 1 enables internal reference.
// R7: Interface pin latched at full-reset release; 0 parallel, 1 serial.
// R8: Serial mode samples lane select at full-reset release, then ignores it.
// R9: Host holds lane select high for two lanes, low for lane A only.
// R10: Hardware mode latches burst, sequencer and oversampling pins at full release.
// R11: A low pulse of 40 to 500 ns is partial; starts allowed 50 ns later.
// R12: A low pulse of 1.2 us or more is full; starts allowed 15 ms later.
// R13: Partial reset reinitialises sequencer, filter, serial port and both converters.
// R14: Partial reset discards the result in progress but keeps all configuration.
// R15: Host runs one dummy conversion after a software-mode partial reset.
// R16: Full reset returns everything, including latched selections, to defaults.
// R17: Hardware mode polls channel and range pins on exit from any reset.
// R18: Host sets channel pins before the start edge and holds until busy falls.
// R19: Hardware mode range follows the pins directly, without latching.
// R20: Software serial one-lane mode leaves serial output B undriven.
// R21: Top three data pins carry oversampling ratio only in hardware serial mode.
// R22: Reset low time is counted and classified at release; gaps are undefined.
// R23: One mode register, written only on full-reset release, feeds the logic.
`timescale 1ns/1ps
module rcl_reset_config_latch
  import rcl_pkg::*;
#(
  parameter int unsigned FULL_READY_CYCLES = 32'(FULL_READY_CYC_L)
)
(
  // Clock and power-on reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Reset pin from the host, active low.
  input  wire logic              resetPin_n,
  // Strap and configuration pins.
  input  wire logic [1:0]        rangeModeSel,
  input  wire logic              refSourceSel,
  input  wire logic              ifaceSel,
  input  wire logic              serialLaneSel,
  input  wire logic              burstEnPin,
  input  wire logic              seqEnPin,
  input  wire logic [OVS_W-1:0]  topDataPins,
  input  wire logic [CHAN_W-1:0] chanPairSel,
  // Register access request from the interface logic.
  input  wire logic              regAccessReq,
  // Latched configuration.
  output rcl_cfg_s               cfg,
  // Live range, initial channel pair and data pin usage.
  output logic      [1:0]        inputRange,
  output logic      [CHAN_W-1:0] initChanPair,
  output logic                   topPinsAreData,
  // Register access and lane B drive control.
  output logic                   regAccessGrant,
  output logic                   serialOutBEn,
  // Reset pulses to the downstream units.
  output logic                   seqReset,
  output logic                   filterReset,
  output logic                   serialPortReset,
  output logic                   sarReset,
  output logic                   discardResult,
  // Reset classification and readiness.
  output rcl_kind_e              lastKind,
  output logic                   convReady
);

  // Two-flop synchronisers for all pin inputs.
  localparam int SYN_W = 1 + 2 + 1 + 1 + 1 + 1 + 1 + OVS_W + CHAN_W;
  logic [SYN_W-1:0] synMeta;
  logic [SYN_W-1:0] synOut;
  logic [SYN_W-1:0] synIn;
  assign synIn = {resetPin_n, rangeModeSel, refSourceSel, ifaceSel, serialLaneSel,
                  burstEnPin, seqEnPin, topDataPins, chanPairSel};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          synMeta[gi] <= 1'b1;
          synOut[gi]  <= 1'b1;
        end else begin
          synMeta[gi] <= synIn[gi];
          synOut[gi]  <= synMeta[gi];
        end
      end
    end
  endgenerate

  logic              sResetN;
  logic [1:0]        sRange;
  logic              sRef;
  logic              sIface;
  logic              sLane;
  logic              sBurst;
  logic              sSeq;
  logic [OVS_W-1:0]  sOvs;
  logic [CHAN_W-1:0] sChan;
  assign {sResetN, sRange, sRef, sIface, sLane, sBurst, sSeq, sOvs, sChan} = synOut;

  // Low interval measurement.
  logic [PW_CNT_W-1:0] width;
  rcl_pulse_timer u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .pinLow (!sResetN),
    .width  (width)
  );

  logic resetPrev;
  logic releaseEdge;
  assign releaseEdge = sResetN && !resetPrev;

  // Classification at release, counted in cycles.
  rcl_kind_e relKind;
  always_comb begin
    relKind = RCL_UNDEF; // R22
    if (32'(width) >= FULL_MIN_CYC) begin
      relKind = RCL_FULL; // R12
    end else if (32'(width) >= PART_MIN_CYC && 32'(width) <= PART_MAX_CYC) begin
      relKind = RCL_PART; // R11
    end
  end

  // Configuration, classification and readiness state.
  rcl_cfg_s          next_cfg;
  rcl_kind_e         next_lastKind;
  logic [RDY_CNT_W-1:0] readyCnt;
  logic [RDY_CNT_W-1:0] next_readyCnt;
  logic [CHAN_W-1:0] next_initChanPair;
  logic              pulseReset;
  logic              next_pulseReset;

  always_comb begin
    next_cfg          = cfg;
    next_lastKind     = lastKind;
    next_readyCnt     = readyCnt;
    next_initChanPair = initChanPair;
    next_pulseReset   = 1'b0;
    if (!sResetN) begin
      next_readyCnt = '0;
    end else if (readyCnt != '0) begin
      next_readyCnt = readyCnt - 20'h00001;
    end
    if (releaseEdge) begin
      next_lastKind = relKind;
      if (relKind == RCL_FULL) begin
        next_cfg          = CFG_RESET; // R16
        next_cfg.hwMode   = (sRange != RANGE_SW_CODE); // R1 R3 R23
        next_cfg.intRefEn = sRef; // R6 R5
        next_cfg.serialIf = sIface; // R7
        next_cfg.twoLane  = (sIface == IFACE_SERIAL) ? sLane : 1'b0; // R8
        if (sRange != RANGE_SW_CODE) begin
          next_cfg.burst_en_pin  = sBurst; // R10
          next_cfg.seq_en_pin    = sSeq;
          next_cfg.ovsRatio = (sIface == IFACE_SERIAL) ? sOvs : '0; // R21
        end
        next_readyCnt   = RDY_CNT_W'(FULL_READY_CYCLES); // R12
        next_pulseReset = 1'b1;
      end else if (relKind == RCL_PART) begin
        next_readyCnt   = RDY_CNT_W'(PART_READY_CYC); // R11 R14
        next_pulseReset = 1'b1; // R13
      end
      if (relKind != RCL_UNDEF) begin
        next_initChanPair = sChan; // R17
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg          <= CFG_RESET;
      lastKind     <= RCL_NONE;
      readyCnt     <= '0;
      initChanPair <= '0;
      pulseReset   <= 1'b0;
      resetPrev    <= 1'b1;
    end else begin
      cfg          <= next_cfg;
      lastKind     <= next_lastKind;
      readyCnt     <= next_readyCnt;
      initChanPair <= next_initChanPair;
      pulseReset   <= next_pulseReset;
      resetPrev    <= sResetN;
    end
  end

  // Downstream unit resets: held while the pin is low and pulsed at a partial or full release.
  assign seqReset        = pulseReset || !resetPrev; // R13
  assign filterReset     = pulseReset || !resetPrev;
  assign serialPortReset = pulseReset || !resetPrev;
  assign sarReset        = pulseReset || !resetPrev;
  assign discardResult   = pulseReset || !resetPrev; // R14

  assign convReady = sResetN && (readyCnt == '0) &&
                     (lastKind == RCL_PART || lastKind == RCL_FULL);

  // Range follows the pins live in hardware mode, ignored in software mode.
  assign inputRange     = cfg.hwMode ? sRange : RANGE_SW_CODE; // R19 R2
  assign regAccessGrant = regAccessReq && !cfg.hwMode; // R4 R5
  assign serialOutBEn   = cfg.serialIf && cfg.twoLane; // R20
  assign topPinsAreData = !(cfg.hwMode && cfg.serialIf); // R21

  // Assertions.
  sequence s_fullRelease;
    releaseEdge && relKind == RCL_FULL;
  endsequence

  sequence s_partRelease;
    releaseEdge && relKind == RCL_PART;
  endsequence

  sequence s_hwConfigured;
    s_fullRelease ##1 cfg.hwMode;
  endsequence

  sequence s_swConfigured;
    s_fullRelease ##1 !cfg.hwMode;
  endsequence

  AST_MODE_FROM_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // R1
    s_fullRelease |=> cfg.hwMode == ($past(sRange) != RANGE_SW_CODE))
    else $error("Mode not taken from range pins at full release.");

  AST_MODE_STABLE: assert property (@(posedge clk) disable iff (!rst_n) // R3
    !(releaseEdge && relKind == RCL_FULL) |=> $stable(cfg.hwMode))
    else $error("Mode changed without a full reset.");

  AST_REG_REFUSED: assert property (@(posedge clk) disable iff (!rst_n) // R4
    cfg.hwMode |-> !regAccessGrant)
    else $error("Register access granted in hardware mode.");

  AST_REF_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // R6
    s_fullRelease |=> cfg.intRefEn == $past(sRef))
    else $error("Reference select not latched.");

  AST_IFACE_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // R7
    s_fullRelease |=> cfg.serialIf == $past(sIface))
    else $error("Interface select not latched.");

  AST_PART_KEEPS: assert property (@(posedge clk) disable iff (!rst_n) // R14
    s_partRelease |=> $stable(cfg))
    else $error("Partial reset altered configuration.");

  AST_PART_READY: assert property (@(posedge clk) disable iff (!rst_n) // R11
    s_partRelease ##1 sResetN [*2] |-> ##1 convReady)
    else $error("Not ready soon after partial reset.");

  AST_PART_UNITS: assert property (@(posedge clk) disable iff (!rst_n) // R13
    s_partRelease |=> seqReset && filterReset && serialPortReset && sarReset)
    else $error("Partial reset did not reach all units.");

  AST_FULL_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // R12
    s_fullRelease |=> !convReady [*8])
    else $error("Ready too soon after full reset.");

  AST_LANE_B: assert property (@(posedge clk) disable iff (!rst_n) // R20
    (cfg.serialIf && !cfg.twoLane) |-> !serialOutBEn)
    else $error("Lane B driven in one-lane mode.");

  AST_RANGE_LIVE: assert property (@(posedge clk) disable iff (!rst_n) // R19
    cfg.hwMode |-> inputRange == sRange)
    else $error("Range not following pins in hardware mode.");

  AST_LANE_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // R8
    s_fullRelease |=> cfg.twoLane == (($past(sIface) == IFACE_SERIAL) && $past(sLane)))
    else $error("Lane count not latched at full release.");

  AST_FEATURE_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // R10
    s_hwConfigured |-> cfg.burst_en_pin == $past(sBurst) && cfg.seq_en_pin == $past(sSeq))
    else $error("Feature pins not latched in hardware mode.");

  AST_SW_DEFAULTS: assert property (@(posedge clk) disable iff (!rst_n) // R16
    s_swConfigured |-> !cfg.burst_en_pin && !cfg.seq_en_pin && cfg.ovsRatio == '0)
    else $error("Hardware features left set after a full reset to software mode.");

  AST_OVS_PARALLEL: assert property (@(posedge clk) disable iff (!rst_n) // R21
    s_hwConfigured |-> cfg.serialIf || cfg.ovsRatio == '0)
    else $error("Oversampling taken from data pins in parallel mode.");

  AST_CHAN_POLL: assert property (@(posedge clk) disable iff (!rst_n) // R17
    releaseEdge && relKind != RCL_UNDEF |=> initChanPair == $past(sChan))
    else $error("Channel pair not polled at reset exit.");

  AST_UNDEF_KEEPS: assert property (@(posedge clk) disable iff (!rst_n) // R22
    releaseEdge && relKind == RCL_UNDEF |=> $stable(cfg) && lastKind == RCL_UNDEF)
    else $error("Undefined reset width altered the configuration.");

  AST_CFG_ONLY_FULL: assert property (@(posedge clk) disable iff (!rst_n) // R23
    !(releaseEdge && relKind == RCL_FULL) |=> $stable(cfg))
    else $error("Mode register written outside a full release.");

  AST_RANGE_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // R2
    !cfg.hwMode |-> inputRange == RANGE_SW_CODE)
    else $error("Range pins followed in software mode.");

  AST_PART_DISCARD: assert property (@(posedge clk) disable iff (!rst_n) // R14
    s_partRelease |=> discardResult)
    else $error("Result not discarded after partial reset.");

  AST_UNITS_HELD: assert property (@(posedge clk) disable iff (!rst_n) // R13
    !resetPrev |-> seqReset && filterReset && serialPortReset && sarReset && discardResult)
    else $error("Unit resets not held while the reset pin is low.");

  AST_FULL_KIND: assert property (@(posedge clk) disable iff (!rst_n) // R12
    s_fullRelease |=> lastKind == RCL_FULL && !convReady)
    else $error("Full reset not classified or ready too early.");

  AST_PART_KIND: assert property (@(posedge clk) disable iff (!rst_n) // R11
    s_partRelease |=> lastKind == RCL_PART && !convReady)
    else $error("Partial reset not classified or ready too early.");

endmodule

// ===== verification/rcl_host_model.sv
// Host model that drives the reset pin and the strap pins.
`timescale 1ns/1ps
module rcl_host_model
  import rcl_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Reset and strap pins.
  output logic                   resetPin_n,
  output logic      [1:0]        rangeModeSel,
  output logic                   refSourceSel,
  output logic                   ifaceSel,
  output logic                   serialLaneSel,
  output logic                   burstEnPin,
  output logic                   seqEnPin,
  output logic      [OVS_W-1:0]  topDataPins,
  output logic      [CHAN_W-1:0] chanPairSel
);
  initial begin
    resetPin_n = 1'h1;
    {rangeModeSel, refSourceSel, ifaceSel, serialLaneSel} = 5'h00;
    {burstEnPin, seqEnPin, topDataPins, chanPairSel} = 8'h00;
  end
  // Sets all straps just after an edge and holds them until the next call.
  task automatic strap(input logic [12:0] v);
    @(posedge clk);
    #1;
    {rangeModeSel, refSourceSel, ifaceSel, serialLaneSel} = v[12:8];
    {burstEnPin, seqEnPin, topDataPins, chanPairSel} = v[7:0];
  endtask
  // Holds reset low for a number of cycles; no conversion is started afterwards.
  task automatic pulse(input int n);
    @(posedge clk);
    #1;
    resetPin_n = 1'h0;
    repeat (n) @(posedge clk);
    #1;
    resetPin_n = 1'h1;
  endtask
endmodule

// ===== verification/tb_reset_config_latch.sv
// Self-checking bench for the reset configuration latch.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin errorCnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_reset_config_latch
  import rcl_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic              regAccessReq;
  logic              resetPin_n;
  logic [1:0]        rangeModeSel;
  logic              refSourceSel, ifaceSel, serialLaneSel, burstEnPin, seqEnPin;
  logic [OVS_W-1:0]  topDataPins;
  logic [CHAN_W-1:0] chanPairSel;
  rcl_cfg_s          cfg;
  logic [1:0]        inputRange;
  logic [CHAN_W-1:0] initChanPair;
  logic              topPinsAreData, regAccessGrant, serialOutBEn, convReady;
  logic              seqReset, filterReset, serialPortReset, sarReset, discardResult;
  rcl_kind_e         lastKind;
  int                errorCnt;
  int                samplesChecked;
  int                cycles;

  logic [4:0]        unitRst;

  rcl_host_model host (
    .clk           (clk),
    .resetPin_n    (resetPin_n),
    .rangeModeSel  (rangeModeSel),
    .refSourceSel  (refSourceSel),
    .ifaceSel      (ifaceSel),
    .serialLaneSel (serialLaneSel),
    .burstEnPin    (burstEnPin),
    .seqEnPin      (seqEnPin),
    .topDataPins   (topDataPins),
    .chanPairSel   (chanPairSel)
  );

  rcl_reset_config_latch #(.FULL_READY_CYCLES(20)) uut (
    .clk             (clk),
    .rst_n           (rst_n),
    .resetPin_n      (resetPin_n),
    .rangeModeSel    (rangeModeSel),
    .refSourceSel    (refSourceSel),
    .ifaceSel        (ifaceSel),
    .serialLaneSel   (serialLaneSel),
    .burstEnPin      (burstEnPin),
    .seqEnPin        (seqEnPin),
    .topDataPins     (topDataPins),
    .chanPairSel     (chanPairSel),
    .regAccessReq    (regAccessReq),
    .cfg             (cfg),
    .inputRange      (inputRange),
    .initChanPair    (initChanPair),
    .topPinsAreData  (topPinsAreData),
    .regAccessGrant  (regAccessGrant),
    .serialOutBEn    (serialOutBEn),
    .seqReset        (seqReset),
    .filterReset     (filterReset),
    .serialPortReset (serialPortReset),
    .sarReset        (sarReset),
    .discardResult   (discardResult),
    .lastKind        (lastKind),
    .convReady       (convReady)
  );

  assign unitRst = {seqReset, filterReset, serialPortReset, sarReset, discardResult};

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic stopTest();
    $display("checks %0d errors %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errorCnt++;
      stopTest();
    end
  end

  initial begin
    errorCnt = 0;
    samplesChecked = 0;
    cycles = 0;
    rst_n = 1'h0;
    regAccessReq = 1'h1;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'h1;
    // Software serial, two lanes, internal reference; feature pins set but unused.
    host.strap(13'h07EA);
    host.pulse(60);
    settle(8);
    `CHK("cfg", 9'h0E0, cfg)
    `CHK("kind", RCL_FULL, lastKind)
    `CHK("ready", 1'h0, convReady)
    `CHK("grant", 1'h1, regAccessGrant)
    `CHK("laneB", 1'h1, serialOutBEn)
    settle(25);
    `CHK("ready", 1'h1, convReady)
    host.strap(13'h1800);
    regAccessReq = 1'h0;
    settle(5);
    `CHK("cfg", 9'h0E0, cfg)
    `CHK("range", 2'h0, inputRange)
    `CHK("grant", 1'h0, regAccessGrant)
    // Software serial, one lane, external reference.
    host.strap(13'h0200);
    regAccessReq = 1'h1;
    host.pulse(60);
    settle(8);
    `CHK("cfg", 9'h040, cfg)
    `CHK("laneB", 1'h0, serialOutBEn)
    // Hardware serial with all feature pins set.
    host.strap(13'h17EE);
    host.pulse(60);
    settle(8);
    `CHK("cfg", 9'h1FD, cfg)
    `CHK("grant", 1'h0, regAccessGrant)
    `CHK("topPins", 1'h0, topPinsAreData)
    `CHK("chan", 3'h6, initChanPair)
    `CHK("range", 2'h2, inputRange)
    host.strap(13'h1B11);
    settle(4);
    `CHK("range", 2'h3, inputRange)
    `CHK("cfg", 9'h1FD, cfg)
    // Partial reset keeps the latched settings; the unit resets are checked while the pin is still held low.
    fork
      host.pulse(10);
      begin
        settle(6);
        `CHK("units", 5'h1F, unitRst)
      end
    join
    settle(8);
    `CHK("kind", RCL_PART, lastKind)
    `CHK("ready", 1'h1, convReady)
    `CHK("cfg", 9'h1FD, cfg)
    `CHK("chan", 3'h1, initChanPair)
    // A width between the two ranges changes nothing but the kind and readiness.
    host.pulse(30);
    settle(8);
    `CHK("kind", RCL_UNDEF, lastKind)
    `CHK("ready", 1'h0, convReady)
    `CHK("cfg", 9'h1FD, cfg)
    // Full reset back to software parallel clears the hardware settings.
    host.strap(13'h05FF);
    host.pulse(60);
    settle(8);
    `CHK("cfg", 9'h080, cfg)
    `CHK("topPins", 1'h1, topPinsAreData)
    `CHK("grant", 1'h1, regAccessGrant)
    stopTest();
  end
endmodule
